// ===== logic/aosa_pkg.sv
// Constants, types and helpers shared by the option-select start controller
package aosa_pkg;

   // Clock and start qualification timing
   localparam int AOSA_CLK_KHZ = 25000;
   localparam int AOSA_QUAL_TIME_US = 10000;
   localparam int AOSA_QUAL_CYCLES = (AOSA_QUAL_TIME_US * AOSA_CLK_KHZ + 999) / 1000;
   localparam int AOSA_QUAL_W = 18;

   // Setting layout: image number in the low byte, port enables above it
   localparam int AOSA_IMG_W = 8;
   localparam int AOSA_PORTS = 4;
   localparam int AOSA_SET_W = AOSA_IMG_W + AOSA_PORTS;
   localparam int AOSA_SET_IMG_LSB = 0;
   localparam int AOSA_SET_PEN_LSB = 8;
   localparam int AOSA_OPT_NUM = 4;
   localparam int AOSA_OPT_IDX_W = 2;

   // Register bus
   localparam int AOSA_ADDR_W = 8;
   localparam int AOSA_DATA_W = 32;
   localparam logic [7:0] AOSA_REG_CTRL = 8'h00;
   localparam logic [7:0] AOSA_REG_STATUS = 8'h04;
   localparam logic [7:0] AOSA_REG_DEFAULT = 8'h08;
   localparam logic [7:0] AOSA_REG_OPT0 = 8'h0C;
   localparam logic [7:0] AOSA_REG_OPT1 = 8'h10;
   localparam logic [7:0] AOSA_REG_OPT2 = 8'h14;
   localparam logic [7:0] AOSA_REG_OPT3 = 8'h18;

   // Field positions
   localparam int AOSA_CTRL_START_BIT = 0;
   localparam int AOSA_STAT_STATE_LSB = 0;
   localparam int AOSA_STAT_LINE_LOW_BIT = 4;
   localparam int AOSA_STAT_OPT_USED_BIT = 5;
   localparam int AOSA_STAT_OPT_IDX_LSB = 6;
   localparam int AOSA_STAT_RESULT_LSB = 8;

   // Reset values
   localparam logic [11:0] AOSA_DEFAULT_RST = 12'hF00;
   localparam logic [11:0] AOSA_OPT_RST = 12'h000;
   localparam logic [3:0] AOSA_RESULT_RST = 4'h0;

   typedef enum logic [3:0] {
      AOSA_ST_RELEASE = 4'b0001,
      AOSA_ST_IDLE = 4'b0010,
      AOSA_ST_PULL = 4'b0100,
      AOSA_ST_RUN = 4'b1000
   } aosa_state_t;

   // Low-true select pins to option index: 11->0, 10->1, 01->2, 00->3
   function automatic logic [1:0] aosa_opt_index(input logic bit1_n, input logic bit0_n);
      aosa_opt_index = {~bit1_n, ~bit0_n};
   endfunction

   // Byte address to option slot, valid only for the four option words
   function automatic logic [1:0] aosa_opt_slot(input logic [7:0] addr);
      logic [7:0] rel;
      rel = addr - AOSA_REG_OPT0;
      aosa_opt_slot = rel[3:2];
   endfunction

   function automatic logic aosa_is_opt(input logic [7:0] addr);
      aosa_is_opt = (addr >= AOSA_REG_OPT0) && (addr <= AOSA_REG_OPT3) && (addr[1:0] == 2'h0);
   endfunction

endpackage

// ===== logic/aosa_low_qual.sv
// Qualifier: reports when the start/busy line has stayed low long enough
`timescale 1ns/10ps
`default_nettype none

module aosa_low_qual
   import aosa_pkg::*;
#(
   parameter int QUAL_CYCLES = AOSA_QUAL_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic line_low,
   output logic qualified
);

   localparam logic [AOSA_QUAL_W-1:0] QUAL_LAST = AOSA_QUAL_W'(QUAL_CYCLES - 1);

   typedef struct packed {
      logic [AOSA_QUAL_W-1:0] cnt;
      logic done;
   } aosa_qual_state_t;

   aosa_qual_state_t s_q;
   aosa_qual_state_t s_d;

   always_comb begin
      s_d = s_q;
      if (!line_low) begin
         s_d.cnt = '0;
         s_d.done = 1'b0;
      end else if (!s_q.done) begin
         // Saturates once the minimum low time is reached
         if (s_q.cnt == QUAL_LAST) begin
            s_d.done = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + AOSA_QUAL_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign qualified = s_q.done;

endmodule // aosa_low_qual

`default_nettype wire

// ===== logic/aosa_ctrl.sv
// Start/busy line handling and option-select capture for the programmer
//
// Function
// - At qualified start, enable low takes options from the two select pins.
// - Select decode: 11 gives option 0, 10 option 1, 01 option 2, 00 option 3.
// - Undriven pins read high, so default setting is used.
// - Four stored option settings, each image plus port enables, besides default.
// - Each option setting is writable and readable by host software.
// - A local start request pulls the shared start/busy line low.
// - Device holds the line low until its own cycle ends.
// - Cycle starts only after the line stayed low the minimum time.
// - No new cycle until line returned high; equipment releases line.
// - Results high for pass, low for fail, valid at line rise.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module aosa_ctrl
   import aosa_pkg::*;
#(
   parameter int QUAL_CYCLES = AOSA_QUAL_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic [AOSA_ADDR_W-1:0] reg_addr,
   input wire logic [AOSA_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [AOSA_DATA_W-1:0] reg_rdata,
   // Shared open-drain start/busy line
   input wire logic start_busy_in,
   output logic start_busy_out,
   output logic start_busy_oe,
   // Option-select pins, low true
   input wire logic option_choice_enable_n,
   input wire logic option_choice_bit0_n,
   input wire logic option_choice_bit1_n,
   // Local start button, one-cycle pulse
   input wire logic local_start,
   // Programming engine side
   output logic cycle_start,
   output logic [AOSA_IMG_W-1:0] cycle_image,
   output logic [AOSA_PORTS-1:0] cycle_port_en,
   input wire logic cycle_done,
   input wire logic [AOSA_PORTS-1:0] cycle_pass,
   // Per-port pass/fail outputs
   output logic [AOSA_PORTS-1:0] port_result
);

   typedef struct packed {
      aosa_state_t st;
      logic [AOSA_OPT_NUM-1:0][AOSA_SET_W-1:0] opt;
      logic [AOSA_SET_W-1:0] dflt;
      logic [AOSA_IMG_W-1:0] img;
      logic [AOSA_PORTS-1:0] pen;
      logic start;
      logic opt_used;
      logic [AOSA_OPT_IDX_W-1:0] opt_idx;
      logic [AOSA_PORTS-1:0] result;
      logic [AOSA_DATA_W-1:0] rdata;
   } aosa_ctrl_state_t;

   aosa_ctrl_state_t s_q;
   aosa_ctrl_state_t s_d;

   logic line_low;
   logic qualified;
   logic sw_start;
   logic [AOSA_SET_W-1:0] chosen;
   logic [AOSA_OPT_IDX_W-1:0] sel_idx;
   logic [AOSA_DATA_W-1:0] status_word;

   // Image and port-enable fields of one stored setting
   function automatic logic [AOSA_IMG_W-1:0] set_image(input logic [AOSA_SET_W-1:0] s);
      return s[AOSA_SET_IMG_LSB +: AOSA_IMG_W];
   endfunction

   function automatic logic [AOSA_PORTS-1:0] set_ports(input logic [AOSA_SET_W-1:0] s);
      return s[AOSA_SET_PEN_LSB +: AOSA_PORTS];
   endfunction

   assign line_low = ~start_busy_in;

   aosa_low_qual #(
      .QUAL_CYCLES(QUAL_CYCLES)
   ) u_qual (
      .sys_clk(sys_clk),
      .rst(rst),
      .line_low(line_low),
      .qualified(qualified)
   );

   assign sw_start = reg_wr && (reg_addr == AOSA_REG_CTRL) && reg_wdata[AOSA_CTRL_START_BIT];

   assign sel_idx = aosa_opt_index(option_choice_bit1_n, option_choice_bit0_n);

   always_comb begin
      if (!option_choice_enable_n) begin
         chosen = s_q.opt[sel_idx];
      end else begin
         chosen = s_q.dflt;
      end
   end

   always_comb begin
      status_word = '0;
      status_word[AOSA_STAT_STATE_LSB +: $bits(aosa_state_t)] = s_q.st;
      status_word[AOSA_STAT_LINE_LOW_BIT] = line_low;
      status_word[AOSA_STAT_OPT_USED_BIT] = s_q.opt_used;
      status_word[AOSA_STAT_OPT_IDX_LSB +: AOSA_OPT_IDX_W] = s_q.opt_idx;
      status_word[AOSA_STAT_RESULT_LSB +: AOSA_PORTS] = s_q.result;
   end

   always_comb begin
      s_d = s_q;
      s_d.start = 1'b0;

      if (reg_wr) begin
         if (reg_addr == AOSA_REG_DEFAULT) begin
            s_d.dflt = reg_wdata[AOSA_SET_W-1:0];
         end else if (aosa_is_opt(reg_addr)) begin
            s_d.opt[aosa_opt_slot(reg_addr)] = reg_wdata[AOSA_SET_W-1:0];
         end
      end

      if (reg_rd) begin
         s_d.rdata = '0;
         if (reg_addr == AOSA_REG_STATUS) begin
            s_d.rdata = status_word;
         end else if (reg_addr == AOSA_REG_DEFAULT) begin
            s_d.rdata[AOSA_SET_W-1:0] = s_q.dflt;
         end else if (aosa_is_opt(reg_addr)) begin
            s_d.rdata[AOSA_SET_W-1:0] = s_q.opt[aosa_opt_slot(reg_addr)];
         end
      end

      unique case (s_q.st)
         AOSA_ST_RELEASE: begin
            // Wait for line high
            // Others in the array may still hold it low
            if (!line_low) begin
               s_d.st = AOSA_ST_IDLE;
            end
         end
         AOSA_ST_IDLE: begin
            if (qualified) begin
               s_d.st = AOSA_ST_RUN;
               s_d.start = 1'b1;
               s_d.img = set_image(chosen);
               s_d.pen = set_ports(chosen);
               s_d.opt_used = ~option_choice_enable_n;
               s_d.opt_idx = sel_idx;
            end else if (local_start || sw_start) begin
               s_d.st = AOSA_ST_PULL;
            end
         end
         AOSA_ST_PULL: begin
            if (qualified) begin
               s_d.st = AOSA_ST_RUN;
               s_d.start = 1'b1;
               s_d.img = set_image(chosen);
               s_d.pen = set_ports(chosen);
               s_d.opt_used = ~option_choice_enable_n;
               s_d.opt_idx = sel_idx;
            end
         end
         AOSA_ST_RUN: begin
            if (cycle_done) begin
               s_d.result = cycle_pass;
               s_d.st = AOSA_ST_RELEASE;
            end
         end
         default: begin
            s_d.st = AOSA_ST_RELEASE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_q.st <= AOSA_ST_RELEASE;
         s_q.opt <= {AOSA_OPT_NUM{AOSA_OPT_RST}};
         s_q.dflt <= AOSA_DEFAULT_RST;
         s_q.img <= '0;
         s_q.pen <= '0;
         s_q.start <= 1'b0;
         s_q.opt_used <= 1'b0;
         s_q.opt_idx <= '0;
         s_q.result <= AOSA_RESULT_RST;
         s_q.rdata <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign start_busy_oe = (s_q.st == AOSA_ST_PULL) || (s_q.st == AOSA_ST_RUN);
   // Open drain: the pin is only ever pulled low, never driven high
   assign start_busy_out = 1'b0;

   assign reg_rdata = s_q.rdata;
   assign cycle_start = s_q.start;
   assign cycle_image = s_q.img;
   assign cycle_port_en = s_q.pen;
   assign port_result = s_q.result;

endmodule // aosa_ctrl

`default_nettype wire

// ===== bench/aosa_ctrl_chk.sv
// Concurrent checks on the start/busy and option capture ports
`timescale 1ns/10ps
`default_nettype none
module aosa_ctrl_chk
   import aosa_pkg::*;
#(parameter int QUAL_CYCLES = 8) (
   input wire logic sys_clk, input wire logic rst,
   input wire logic [7:0] reg_addr, input wire logic [31:0] reg_wdata,
   input wire logic reg_wr, input wire logic reg_rd, input wire logic [31:0] reg_rdata,
   input wire logic start_busy_in, input wire logic start_busy_out,
   input wire logic start_busy_oe, input wire logic option_choice_enable_n,
   input wire logic option_choice_bit0_n, input wire logic option_choice_bit1_n,
   input wire logic local_start, input wire logic cycle_start,
   input wire logic [7:0] cycle_image, input wire logic [3:0] cycle_port_en,
   input wire logic cycle_done, input wire logic [3:0] cycle_pass,
   input wire logic [3:0] port_result
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [31:0] low_q;
   logic arm_q;
   // Consecutive low samples and high-seen flag
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         low_q <= 32'h0;
         arm_q <= 1'b0;
      end else begin
         low_q <= start_busy_in ? 32'h0 : (low_q == 32'hFFFF_FFFF ? low_q : low_q + 32'h1);
         arm_q <= cycle_start ? 1'b0 : (arm_q | start_busy_in);
      end
   end
   sequence s_pulse;
      cycle_start ##1 !cycle_start;
   endsequence
   property p_od; start_busy_out == 1'b0; endproperty
   property p_start_pull; cycle_start |-> start_busy_oe; endproperty
   property p_pulse; cycle_start |-> s_pulse; endproperty
   property p_release; $fell(start_busy_oe) && !$past(rst) |-> $past(cycle_done); endproperty
   property p_result;
      $fell(start_busy_oe) && !$past(rst) |-> port_result == $past(cycle_pass);
   endproperty
   property p_qual; cycle_start |-> $past(low_q) >= 32'(QUAL_CYCLES); endproperty
   property p_rearm; cycle_start |-> arm_q; endproperty
   property p_hold;
      !cycle_start && !$past(rst) |-> $stable({cycle_image, cycle_port_en});
   endproperty
   a_od: assert property (p_od) else $error("line driven high");
   a_start_pull: assert property (p_start_pull) else $error("start without pull");
   a_pulse: assert property (p_pulse) else $error("start pulse too long");
   a_release: assert property (p_release) else $error("line freed early");
   a_result: assert property (p_result) else $error("result not valid");
   a_qual: assert property (p_qual) else $error("start too soon");
   a_rearm: assert property (p_rearm) else $error("start without line high");
   a_hold: assert property (p_hold) else $error("setting changed mid cycle");
endmodule // aosa_ctrl_chk
`default_nettype wire

// ===== bench/aosa_ate_model.sv
// Test-equipment model sinking the shared start/busy line
`timescale 1ns/10ps
`default_nettype none
module aosa_ate_model (
   input wire logic sys_clk,
   input wire logic go,
   input wire logic [7:0] hold_len,
   output logic sink
);
   logic [7:0] cnt_q = 8'h00;
   always_ff @(posedge sys_clk) begin
      if (go) begin
         cnt_q <= hold_len;
      end else if (cnt_q != 8'h00) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
   assign sink = (cnt_q != 8'h00);
endmodule // aosa_ate_model
`default_nettype wire

// ===== bench/aosa_ctrl_tb.sv
// Self-checking bench for the option-select start controller
`timescale 1ns/10ps
`default_nettype none
module aosa_ctrl_tb
   import aosa_pkg::*;
   ;
   localparam int QC = 8;
   logic sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, sink;
   logic [7:0] reg_addr = 8'h00, hold_len = 8'h00, cycle_image;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic start_busy_in, start_busy_out, start_busy_oe, cycle_start;
   logic option_choice_enable_n = 1'b1, option_choice_bit0_n = 1'b1;
   logic option_choice_bit1_n = 1'b1, local_start = 1'b0, cycle_done = 1'b0;
   logic [3:0] cycle_pass = 4'h0, cycle_port_en, port_result;
   int fail_count = 0, n_tests = 0, cyc = 0, starts = 0;
   // Wired line with pull-up
   assign start_busy_in = ~(sink | (start_busy_oe & ~start_busy_out));
   aosa_ctrl #(.QUAL_CYCLES(QC)) dut_u (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .start_busy_in, .start_busy_out, .start_busy_oe,
      .option_choice_enable_n, .option_choice_bit0_n, .option_choice_bit1_n, .local_start,
      .cycle_start, .cycle_image, .cycle_port_en, .cycle_done, .cycle_pass, .port_result);
   aosa_ate_model ate_u (.sys_clk, .go, .hold_len, .sink);
   initial forever #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cycle_start === 1'b1) starts <= starts + 1;
      if (cyc == 2000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", e, reg_rdata);
   endtask
   function automatic logic [11:0] opt(input int k);
      return {4'(k + 1), 8'(48 + k)};
   endfunction
   // Start source: 0 test equipment, 1 button, 2 soft start write
   task automatic run(input logic [1:0] src, input logic [2:0] pins, input logic [11:0] e,
                      input logic [3:0] p);
      int i;
      @(posedge sys_clk);
      {option_choice_enable_n, option_choice_bit1_n, option_choice_bit0_n} <= pins;
      local_start <= (src == 2'h1);
      go <= (src == 2'h0);
      hold_len <= 8'(QC + 4);
      reg_addr <= AOSA_REG_CTRL;
      reg_wdata <= 32'h0000_0001;
      reg_wr <= (src == 2'h2);
      @(posedge sys_clk);
      local_start <= 1'b0;
      go <= 1'b0;
      reg_wr <= 1'b0;
      for (i = 0; i < 40 && cycle_start !== 1'b1; i++) tick(1);
      chk("cycle_image", 32'(e[7:0]), 32'(cycle_image));
      chk("cycle_port_en", 32'(e[11:8]), 32'(cycle_port_en));
      @(posedge sys_clk);
      {option_choice_enable_n, option_choice_bit1_n, option_choice_bit0_n} <= ~pins;
      tick(QC + 6);
      chk("line held", 32'h0, 32'(start_busy_in));
      @(posedge sys_clk);
      cycle_done <= 1'b1;
      cycle_pass <= p;
      @(posedge sys_clk);
      cycle_done <= 1'b0;
      #1;
      chk("port_result", 32'(p), 32'(port_result));
      chk("cycle_image", 32'(e[7:0]), 32'(cycle_image));
      tick(2);
      chk("line free", 32'h1, 32'(start_busy_in));
   endtask
   initial begin
      int k;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      rd(AOSA_REG_DEFAULT, 32'h0000_0F00);
      chk("port_result", 32'h0, 32'(port_result));
      chk("cycle_image", 32'h0, 32'(cycle_image));
      rd(8'h40, 32'h0);
      wr(AOSA_REG_DEFAULT, 32'hFFFF_F5C3);
      rd(AOSA_REG_DEFAULT, 32'h0000_05C3);
      for (k = 0; k < 4; k++) begin
         rd(AOSA_REG_OPT0 + 8'(4 * k), 32'h0);
         wr(AOSA_REG_OPT0 + 8'(4 * k), 32'(opt(k)));
         rd(AOSA_REG_OPT0 + 8'(4 * k), 32'(opt(k)));
      end
      $display("register test done");
      for (k = 0; k < 4; k++) run(2'h0, {1'b0, ~2'(k)}, opt(k), 4'(k) ^ 4'h6);
      run(2'h0, 3'b100, 12'h5C3, 4'hF);
      run(2'h1, 3'b111, 12'h5C3, 4'h0);
      run(2'h2, 3'b001, opt(2), 4'h9);
      rd(AOSA_REG_STATUS, 32'h0000_09A2);
      $display("cycle tests done");
      k = starts;
      @(posedge sys_clk);
      go <= 1'b1;
      hold_len <= 8'(QC - 1);
      @(posedge sys_clk);
      go <= 1'b0;
      tick(30);
      chk("starts", 32'(k), 32'(starts));
      @(posedge sys_clk);
      go <= 1'b1;
      hold_len <= 8'(4 * QC + 20);
      @(posedge sys_clk);
      go <= 1'b0;
      tick(QC + 6);
      @(posedge sys_clk);
      cycle_done <= 1'b1;
      @(posedge sys_clk);
      cycle_done <= 1'b0;
      tick(4 * QC + 20);
      chk("starts", 32'(k + 1), 32'(starts));
      $display("pull length tests done");
      wrap_up();
   end
endmodule // aosa_ctrl_tb
bind aosa_ctrl aosa_ctrl_chk #(.QUAL_CYCLES(QUAL_CYCLES)) chk_u (.sys_clk, .rst, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .start_busy_in, .start_busy_out, .start_busy_oe,
   .option_choice_enable_n, .option_choice_bit0_n, .option_choice_bit1_n, .local_start,
   .cycle_start, .cycle_image, .cycle_port_en, .cycle_done, .cycle_pass, .port_result);
`default_nettype wire
